// File: fcwp_pkg.sv
// constants shared by the fir configuration write port
package fcwp_pkg;
	// ----------------------------------------
	// register offsets on the 9-bit address bus
	// ----------------------------------------
	localparam logic [8:0] FCWP_ADDR_MODE = 9'h000;
	localparam logic [8:0] FCWP_ADDR_FMT = 9'h001;
	localparam int FCWP_COEF_SEL_BIT = 8;
	localparam int FCWP_BANK_BIT = 7;
	localparam int FCWP_SET_LSB = 2;
	localparam int FCWP_SET_W = 5;
	localparam int FCWP_TAP_LSB = 0;
	localparam int FCWP_TAP_W = 2;

	// ----------------------------------------
	// filter_mode_word fields
	// ----------------------------------------
	localparam int FCWP_DF_LSB = 0;
	localparam int FCWP_DF_W = 4;
	localparam int FCWP_SINGLE_BIT = 4;
	localparam int FCWP_SYM_BIT = 5;
	localparam int FCWP_ODD_A_BIT = 6;
	localparam int FCWP_ODD_B_BIT = 7;
	localparam int FCWP_BSRC_BIT = 8;

	// ----------------------------------------
	// format_round_word fields
	// ----------------------------------------
	localparam int FCWP_FMT_LSB = 0;
	localparam int FCWP_FMT_W = 4;
	localparam int FCWP_REV_BIT = 4;
	localparam int FCWP_RPOS_LSB = 5;
	localparam int FCWP_RPOS_W = 4;
	localparam int FCWP_RND_BIT = 9;

	// ----------------------------------------
	// values after reset
	// ----------------------------------------
	localparam logic [9:0] FCWP_MODE_RST = 10'h000;
	localparam logic [9:0] FCWP_FMT_RST = 10'h210;

	// ----------------------------------------
	// cycle counts
	// ----------------------------------------
	localparam logic [2:0] FCWP_RST_CYCLES = 3'h6;
	localparam int FCWP_BLOCK_TRANSFER_STROBE_EVEN = 3;
	localparam int FCWP_BLOCK_TRANSFER_STROBE_ODD = 4;
	localparam int FCWP_LATENCY = 8;
	localparam int FCWP_SYNC_STAGES = 3;
endpackage

// File: fcwp_sync.sv
// three flip-flop input synchroniser with agreement flag
`timescale 1ns/10ps
`default_nettype none
module fcwp_sync #(
	parameter int WIDTH = 20,
	parameter int STAGES = 3
) (
	// clock and reset
	input wire logic clock_in,
	input wire logic nrst_in,
	// asynchronous input and synchronised result
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out,
	output logic agree_out
);
	logic [STAGES-1:0][WIDTH-1:0] stage_ff;

	// the outputs below read stages two and three only
	initial begin
		if (STAGES != 3) begin
			$error("fcwp_sync needs exactly three stages");
		end
	end

	// shift chain; the first stage feeds only the second
	// resets all ones so an idle-high strobe shows no false rise after reset
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			stage_ff <= '1;
		end else begin
			stage_ff <= {stage_ff[STAGES-2:0], async_in};
		end
	end

	assign sync_out = stage_ff[2];
	assign agree_out = (stage_ff[1] == stage_ff[2]);
endmodule
`default_nettype wire

// File: fcwp_top.sv
// write-only configuration port and control front end of the dual fir
`timescale 1ns/10ps
`default_nettype none
module fcwp_top
	import fcwp_pkg::*;
#(
	parameter int COEF_SETS = 32,
	parameter int TAPS_PER_BANK = 4
) (
	// clock and reset
	input wire logic clock_in,
	input wire logic nrst_in,
	// microprocessor write port, write only with no readback
	input wire logic [9:0] config_data_in,
	input wire logic [8:0] config_addr_in,
	input wire logic write_strobe_n_in,
	// filter-clock controls
	input wire logic [4:0] coef_set_select_in,
	input wire logic block_transfer_strobe_n_in,
	input wire logic shift_enable_n_in,
	// internal reset and timing
	output logic filter_reset_out,
	output logic block_transfer_strobe_a_n_out,
	output logic block_transfer_strobe_b_n_out,
	output logic result_valid_out,
	// mode settings from filter_mode_word
	output logic [3:0] decim_factor_out,
	output logic single_mode_out,
	output logic odd_symmetric_out,
	output logic odd_taps_a_out,
	output logic odd_taps_b_out,
	output logic b_input_select_out,
	// settings from format_round_word
	output logic [3:0] number_format_out,
	output logic reversal_off_out,
	output logic [3:0] round_position_out,
	output logic round_off_out,
	// active coefficient sets
	output logic [3:0][9:0] coef_a_out,
	output logic [3:0][9:0] coef_b_out
);
	// ----------------------------------------
	// elaboration checks
	// ----------------------------------------
	// the coefficient address field is fixed at 5 set bits and 2 tap bits
	initial begin
		if (COEF_SETS != 32 || TAPS_PER_BANK != 4) begin
			$error("fcwp_top supports 32 sets of 4 taps per bank only");
		end
	end

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic strobe_hi;
		logic [9:0] mode_word;
		logic [9:0] fmt_word;
		logic [1:0][31:0][3:0][9:0] coef;
		logic [3:0][9:0] coef_a;
		logic [3:0][9:0] coef_b;
		logic [2:0] rst_cnt;
		logic rst_act;
		logic [2:0] block_transfer_strobe_pipe;
		logic block_transfer_strobe_a;
		logic block_transfer_strobe_b;
		logic [7:0] valid_pipe;
	} fcwp_state_t;

	fcwp_state_t state_ff;
	fcwp_state_t nxt_state;

	logic [19:0] port_sync;
	logic port_agree;
	logic sync_strobe;
	logic [8:0] sync_addr;
	logic [9:0] sync_data;
	logic wr_evt;
	logic ctrl_wr;
	logic coef_wr;

	// ----------------------------------------
	// write port synchroniser
	// ----------------------------------------
	// strobe, address and data cross together so they age alike
	fcwp_sync #(
		.WIDTH(20),
		.STAGES(FCWP_SYNC_STAGES)
	) u_port_sync (
		.clock_in(clock_in),
		.nrst_in(nrst_in),
		.async_in({write_strobe_n_in, config_addr_in, config_data_in}),
		.sync_out(port_sync),
		.agree_out(port_agree)
	);

	assign sync_strobe = port_sync[19];
	assign sync_addr = port_sync[18:10];
	assign sync_data = port_sync[9:0];

	// ----------------------------------------
	// write decode
	// ----------------------------------------
	// a rising strobe counts once stages two and three agree
	assign wr_evt = port_agree && sync_strobe && !state_ff.strobe_hi;
	// reserved and unmapped low addresses fall through with no effect
	assign ctrl_wr = wr_evt && (sync_addr == FCWP_ADDR_MODE || sync_addr == FCWP_ADDR_FMT);
	assign coef_wr = wr_evt && sync_addr[FCWP_COEF_SEL_BIT];

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		nxt_state = state_ff;
		// track the settled strobe level
		if (port_agree) begin
			nxt_state.strobe_hi = sync_strobe;
		end
		// control words stay writable during internal reset
		if (ctrl_wr && sync_addr == FCWP_ADDR_MODE) begin
			nxt_state.mode_word = sync_data;
		end
		if (ctrl_wr && sync_addr == FCWP_ADDR_FMT) begin
			nxt_state.fmt_word = sync_data;
		end
		// one addressed write per coefficient
		if (coef_wr) begin
			nxt_state.coef[sync_addr[FCWP_BANK_BIT]]
				[sync_addr[FCWP_SET_LSB +: FCWP_SET_W]]
				[sync_addr[FCWP_TAP_LSB +: FCWP_TAP_W]] = sync_data;
		end
		// reset count restarts on every control write; coefficients untouched
		if (ctrl_wr) begin
			nxt_state.rst_cnt = FCWP_RST_CYCLES;
		end else if (state_ff.rst_cnt != 3'h0) begin
			nxt_state.rst_cnt = state_ff.rst_cnt - 3'h1;
		end
		nxt_state.rst_act = (nxt_state.rst_cnt != 3'h0);
		// set select read every clock, so sets may swap cycle to cycle
		nxt_state.coef_a = state_ff.coef[0][coef_set_select_in];
		nxt_state.coef_b = state_ff.coef[1][coef_set_select_in];
		// transfer strobe pipeline; tap point set by odd or even length
		nxt_state.block_transfer_strobe_pipe = {state_ff.block_transfer_strobe_pipe[1:0], block_transfer_strobe_n_in};
		nxt_state.block_transfer_strobe_a = state_ff.mode_word[FCWP_ODD_A_BIT] ?
			state_ff.block_transfer_strobe_pipe[FCWP_BLOCK_TRANSFER_STROBE_ODD-2] : state_ff.block_transfer_strobe_pipe[FCWP_BLOCK_TRANSFER_STROBE_EVEN-2];
		nxt_state.block_transfer_strobe_b = state_ff.mode_word[FCWP_ODD_B_BIT] ?
			state_ff.block_transfer_strobe_pipe[FCWP_BLOCK_TRANSFER_STROBE_ODD-2] : state_ff.block_transfer_strobe_pipe[FCWP_BLOCK_TRANSFER_STROBE_EVEN-2];
		// result marker follows each shifted sample by the pipeline depth
		nxt_state.valid_pipe = {state_ff.valid_pipe[FCWP_LATENCY-2:0], !shift_enable_n_in};
		// internal reset flushes samples in flight, not configuration
		if (nxt_state.rst_act) begin
			nxt_state.valid_pipe = '0;
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_ff <= '{
				strobe_hi: 1'b1,
				mode_word: FCWP_MODE_RST,
				fmt_word: FCWP_FMT_RST,
				coef: '0,
				coef_a: '0,
				coef_b: '0,
				rst_cnt: 3'h0,
				rst_act: 1'b0,
				block_transfer_strobe_pipe: 3'h7,
				block_transfer_strobe_a: 1'b1,
				block_transfer_strobe_b: 1'b1,
				valid_pipe: 8'h00
			};
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ----------------------------------------
	// outputs, all straight from the state register
	// ----------------------------------------
	assign filter_reset_out = state_ff.rst_act;
	assign block_transfer_strobe_a_n_out = state_ff.block_transfer_strobe_a;
	assign block_transfer_strobe_b_n_out = state_ff.block_transfer_strobe_b;
	assign result_valid_out = state_ff.valid_pipe[FCWP_LATENCY-1];
	// decimation coded as delays between taps minus one
	assign decim_factor_out = state_ff.mode_word[FCWP_DF_LSB +: FCWP_DF_W];
	// single mode both cascades the cells and makes the output stage add
	assign single_mode_out = state_ff.mode_word[FCWP_SINGLE_BIT];
	assign odd_symmetric_out = state_ff.mode_word[FCWP_SYM_BIT];
	assign odd_taps_a_out = state_ff.mode_word[FCWP_ODD_A_BIT];
	assign odd_taps_b_out = state_ff.mode_word[FCWP_ODD_B_BIT];
	assign b_input_select_out = state_ff.mode_word[FCWP_BSRC_BIT];
	// format bits: A data, A coef, B data, B coef; 1 means two's complement
	assign number_format_out = state_ff.fmt_word[FCWP_FMT_LSB +: FCWP_FMT_W];
	// reversal and rounding enables are active low in the word
	assign reversal_off_out = state_ff.fmt_word[FCWP_REV_BIT];
	assign round_position_out = state_ff.fmt_word[FCWP_RPOS_LSB +: FCWP_RPOS_W];
	assign round_off_out = state_ff.fmt_word[FCWP_RND_BIT];
	assign coef_a_out = state_ff.coef_a;
	assign coef_b_out = state_ff.coef_b;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!nrst_in);

	logic [3:0][9:0] exp_coef_a;
	assign exp_coef_a = state_ff.coef[0][coef_set_select_in];

	a_strobe_capture: assert property ((!write_strobe_n_in [*3] ##1 write_strobe_n_in [*3])
		|=> wr_evt) else $error("strobe rise not captured");
	a_mode_store: assert property (ctrl_wr && sync_addr == FCWP_ADDR_MODE
		|=> state_ff.mode_word == $past(sync_data)) else $error("mode word not stored");
	a_fmt_during_rst: assert property (filter_reset_out && ctrl_wr && sync_addr == FCWP_ADDR_FMT
		|=> state_ff.fmt_word == $past(sync_data)) else $error("write lost in reset");
	a_rst_six_cycles: assert property (ctrl_wr
		|=> filter_reset_out [*6]) else $error("internal reset too short");
	a_rst_ends: assert property ((ctrl_wr ##1 !ctrl_wr [*6])
		|=> !filter_reset_out) else $error("internal reset too long");
	a_coef_kept: assert property (filter_reset_out && !coef_wr
		|=> $stable(state_ff.coef)) else $error("coefficients disturbed");
	a_reserved_ignored: assert property (wr_evt && !ctrl_wr && !coef_wr
		|=> $stable(state_ff.mode_word) && $stable(state_ff.fmt_word))
		else $error("reserved write changed config");
	a_block_transfer_strobe_even: assert property (!odd_taps_a_out [*4]
		|-> block_transfer_strobe_a_n_out == $past(block_transfer_strobe_n_in, 3))
		else $error("even tap strobe delay wrong");
	a_block_transfer_strobe_odd: assert property (odd_taps_b_out [*5]
		|-> block_transfer_strobe_b_n_out == $past(block_transfer_strobe_n_in, 4))
		else $error("odd tap strobe delay wrong");
	a_valid_latency: assert property ((!shift_enable_n_in ##1 !filter_reset_out [*8])
		|-> result_valid_out) else $error("result latency not eight");
	a_coef_select: assert property (1'b1
		|=> coef_a_out == $past(exp_coef_a)) else $error("wrong coefficient set");

	c_ctrl_write: cover property (ctrl_wr);
	c_coef_write: cover property (coef_wr && sync_addr[FCWP_BANK_BIT]);
	c_rst_retrigger: cover property (filter_reset_out && ctrl_wr);
	c_result_out: cover property ($rose(result_valid_out));
endmodule
`default_nettype wire

// File: fcwp_host.sv
// microprocessor model that loads the configuration write port
`timescale 1ns/10ps
`default_nettype none
module fcwp_host (
	// filter clock, only used to pace the bus cycles
	input wire logic clock_in,
	// write port toward the device
	output logic [9:0] config_data_out,
	output logic [8:0] config_addr_out,
	output logic write_strobe_n_out
);
	// ----------------------------------------
	// bus cycles
	// ----------------------------------------
	// idle bus from time zero, strobe inactive
	initial begin
		config_data_out = 10'h000;
		config_addr_out = 9'h000;
		write_strobe_n_out = 1'b1;
	end

	// strobe low 3 clocks, rise latches; address and data held 3 more clocks
	task automatic write_word(input logic [8:0] addr, input logic [9:0] data);
		// reserved control space is never touched
		if (addr >= 9'h002 && addr <= 9'h011) return;
		write_strobe_n_out = 1'b0;
		config_addr_out = addr;
		config_data_out = data;
		repeat (3) @(posedge clock_in);
		#1 write_strobe_n_out = 1'b1;
		repeat (3) @(posedge clock_in);
		#1;
	endtask

	// hold time over: stale values inverted so nothing relies on them
	task automatic release_bus;
		config_data_out = ~config_data_out;
		config_addr_out = ~config_addr_out;
	endtask
endmodule
`default_nettype wire

// File: fcwp_top_test.sv
// self-checking bench for the fir configuration write port
`timescale 1ns/10ps
`default_nettype none
module fcwp_top_test;
	// ----------------------------------------
	// signals and instances
	// ----------------------------------------
	logic clock_in = 1'b0;
	logic nrst_in = 1'b0;
	logic [9:0] cfg_data;
	logic [8:0] cfg_addr;
	logic wr_n;
	logic [4:0] coef_set_select_in = 5'h00;
	logic block_transfer_strobe_n = 1'b1;
	logic shift_n = 1'b1;
	logic filter_reset_out, block_transfer_strobe_a_n_out, block_transfer_strobe_b_n_out, result_valid_out;
	logic single_mode_out, odd_symmetric_out, odd_taps_a_out, odd_taps_b_out;
	logic b_input_select_out, reversal_off_out, round_off_out;
	logic [3:0] decim_factor_out, number_format_out, round_position_out;
	logic [3:0][9:0] coef_a_out, coef_b_out;
	int n_fail = 0;
	int n_tests = 0;
	int n;

	fcwp_host i_fcwp_host (.clock_in, .config_data_out(cfg_data),
		.config_addr_out(cfg_addr), .write_strobe_n_out(wr_n));

	fcwp_top i_fcwp_top (.clock_in, .nrst_in, .config_data_in(cfg_data),
		.config_addr_in(cfg_addr), .write_strobe_n_in(wr_n), .coef_set_select_in,
		.block_transfer_strobe_n_in(block_transfer_strobe_n), .shift_enable_n_in(shift_n),
		.filter_reset_out, .block_transfer_strobe_a_n_out, .block_transfer_strobe_b_n_out, .result_valid_out,
		.decim_factor_out, .single_mode_out, .odd_symmetric_out, .odd_taps_a_out,
		.odd_taps_b_out, .b_input_select_out, .number_format_out, .reversal_off_out,
		.round_position_out, .round_off_out, .coef_a_out, .coef_b_out);

	// 50 MHz filter clock
	always #10 clock_in = ~clock_in;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic tick;
		@(posedge clock_in);
		#1;
	endtask

	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wrap_up;
		if (n_fail == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// bounded wait for the internal reset, then its length in clocks
	task automatic run_len(output int len);
		int i;
		for (i = 0; i < 40 && filter_reset_out !== 1'b1; i++) tick();
		for (len = 0; len < 40 && filter_reset_out === 1'b1; len++) tick();
	endtask

	task automatic check_words(input logic [8:0] m, input logic [9:0] f);
		chk({b_input_select_out, odd_taps_b_out, odd_taps_a_out, odd_symmetric_out,
			single_mode_out, decim_factor_out}, 40'(m));
		chk({round_off_out, round_position_out, reversal_off_out,
			number_format_out}, 40'(f));
	endtask

	// set select flips every clock between set 5 and set 31
	task automatic toggle_sets;
		int k;
		for (k = 0; k < 6; k++) begin
			coef_set_select_in = k[0] ? 5'h1F : 5'h05;
			tick();
			chk(coef_a_out, k[0] ? 40'h0 : {10'h103, 10'h102, 10'h101, 10'h100});
			chk(coef_b_out, k[0] ? {10'h3F3, 10'h3F2, 10'h3F1, 10'h3F0} : 40'h0);
		end
	endtask

	// one-clock pulses on transfer strobe and shift enable
	task automatic pulse_check;
		int k;
		block_transfer_strobe_n = 1'b0;
		shift_n = 1'b0;
		for (k = 1; k <= 10; k++) begin
			tick();
			chk({block_transfer_strobe_a_n_out, block_transfer_strobe_b_n_out, result_valid_out}, {k != 4, k != 3, k == 8});
			block_transfer_strobe_n = 1'b1;
			shift_n = 1'b1;
		end
	endtask

	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	// the whole run is well under 1000 clocks, so 10000 means a hang
	initial begin
		#200000;
		n_fail++;
		wrap_up();
	end

	initial begin
		repeat (10) tick();
		nrst_in = 1'b1;
		repeat (4) tick();
		check_words(9'h000, 10'h210);
		chk({filter_reset_out, block_transfer_strobe_a_n_out, block_transfer_strobe_b_n_out, result_valid_out}, 40'h6);
		// second control write lands while the first reset still counts
		fork
			begin
				i_fcwp_host.write_word(9'h000, 10'h1F3);
				i_fcwp_host.write_word(9'h001, 10'h365);
			end
			run_len(n);
		join
		chk(40'(n), 40'd12);
		check_words(9'h1F3, 10'h365);
		for (int t = 0; t < 4; t++) begin
			i_fcwp_host.write_word({7'h45, t[1:0]}, {8'h40, t[1:0]});
			i_fcwp_host.write_word({7'h7F, t[1:0]}, {8'hFC, t[1:0]});
		end
		repeat (4) tick();
		toggle_sets();
		// low control space outside both words changes nothing
		i_fcwp_host.write_word(9'h050, 10'h3FF);
		run_len(n);
		chk(40'(n), 40'd0);
		check_words(9'h1F3, 10'h365);
		i_fcwp_host.write_word(9'h000, 10'h040);
		run_len(n);
		chk(40'(n), 40'd6);
		check_words(9'h040, 10'h365);
		toggle_sets();
		pulse_check();
		i_fcwp_host.release_bus();
		wrap_up();
	end
endmodule
`default_nettype wire
